/* File: src/dmbm_params.svh */
// Constants for the data memory bank mapper
// Operation
// - Lower 128 bytes reachable by direct and indirect addressing
// - 00h-1Fh register banks, 20h-2Fh bit area, 30h up general
// - Upper 128 bytes reached indirectly or through banks 2-3, plain data storage
// - Expanded 768 bytes appear at external addresses 0000h-02FFh
// - Enable bit set routes in-range external moves on chip
// - Enable bit resets to one; configuration register resets to 02h
// - Pointer external moves beyond 768 bytes go off chip
// - Enable bit clear sends every external move off chip
// - Index external moves put page bits above index byte
// - Page values 0,1,2 pick expanded pages; page register resets 00h
// - Page 3 or disabled: off chip with port two latch high byte
// - Scratchpad plus expanded RAM form 1KB of sixteen 64-byte banks
// - Banking on: direct 40h-7Fh goes to bank select over low six bits
// - Banked 000h-0FFh is scratchpad, expanded RAM 256 bytes higher
// - Window enable bit one turns banking on, zero turns it off
// - Four-bit select picks bank; control register resets to 01h
`ifndef DMBM_PARAMS_SVH
`define DMBM_PARAMS_SVH
`define DMBM_PAGE_ADDR 8'h85
`define DMBM_BANK_ADDR 8'h86
`define DMBM_SYSTEM_CONFIGURATION_ADDR 8'hbf
`define DMBM_PAGE_RST 8'h00
`define DMBM_BANK_RST 8'h01
`define DMBM_SYSTEM_CONFIGURATION_RST 8'h02
`define DMBM_PAGE_MASK 8'h03
`define DMBM_BANK_MASK 8'h8f
`define DMBM_SYSTEM_CONFIGURATION_MASK 8'h93
`define DMBM_XRAM_EN_BIT 1
`define DMBM_BANK_EN_BIT 7
`define DMBM_XRAM_TOP 16'h02ff
`define DMBM_WIN_LO 8'h40
`define DMBM_WIN_HI 8'h7f
`define DMBM_DIRECT_TOP 8'h7f
`define DMBM_PAGE_OFF 2'h3
`endif

/* File: src/dmbm_pkg.sv */
// Types for the data memory bank mapper
package dmbm_pkg;
   // Access kinds issued by the core
   typedef enum logic [1:0] {
      DMBM_DIRECT = 2'h0,
      DMBM_INDIRECT = 2'h1,
      DMBM_XPTR = 2'h3,
      DMBM_XIDX = 2'h2
   } dmbm_kind_e;
   // Where an access lands
   typedef enum logic [2:0] {
      DMBM_T_NONE = 3'h0,
      DMBM_T_SCRATCH = 3'h1,
      DMBM_T_XRAM = 3'h3,
      DMBM_T_EXTERNAL = 3'h2,
      DMBM_T_SFR = 3'h6
   } dmbm_target_e;
   // Core request
   typedef struct packed {
      logic valid;
      dmbm_kind_e kind;
      logic [7:0] addr8;
      logic [15:0] pointer;
   } dmbm_req_s;
   // Mapped result
   typedef struct packed {
      logic valid;
      dmbm_target_e target;
      logic [15:0] addr;
   } dmbm_map_s;
   // Block state
   typedef struct packed {
      logic [7:0] page_sel;
      logic [7:0] bank_ctl;
      logic [7:0] system_configuration;
      logic [7:0] rdata;
   } dmbm_state_s;
endpackage

/* File: src/dmbm_mapper.sv */
// Data memory address mapper with its three control registers
`timescale 1ns/1ps
`default_nettype none
`include "dmbm_params.svh"
module dmbm_mapper (
   input wire logic clk, // Core clock
   input wire logic resetn, // Async reset, active low
   input wire dmbm_pkg::dmbm_req_s req, // Core data access
   input wire logic [7:0] port_two_latch, // Port two output latch
   input wire logic sfr_wr, // Special register write strobe
   input wire logic sfr_rd, // Special register read strobe
   input wire logic [7:0] sfr_addr, // Special register address
   input wire logic [7:0] sfr_wdata, // Special register write data
   output var logic [7:0] sfr_rdata, // Read data, one cycle after strobe
   output var logic sfr_hit, // Address is one of ours
   output var dmbm_pkg::dmbm_map_s map // Mapped access, combinational
);
   dmbm_pkg::dmbm_state_s st;
   dmbm_pkg::dmbm_state_s next_st;
   logic xram_en;
   logic bank_en;
   logic [3:0] bank_sel;
   logic [1:0] page;

   // Mask decode used by the write path; the hit flag uses is_ours
   function automatic logic [7:0] reg_mask(input logic [7:0] a);
      case (a)
         `DMBM_PAGE_ADDR: reg_mask = `DMBM_PAGE_MASK;
         `DMBM_BANK_ADDR: reg_mask = `DMBM_BANK_MASK;
         `DMBM_SYSTEM_CONFIGURATION_ADDR: reg_mask = `DMBM_SYSTEM_CONFIGURATION_MASK;
         default: reg_mask = 8'h00;
      endcase
   endfunction

   function automatic logic is_ours(input logic [7:0] a);
      is_ours = (a == `DMBM_PAGE_ADDR) || (a == `DMBM_BANK_ADDR) || (a == `DMBM_SYSTEM_CONFIGURATION_ADDR);
   endfunction

   // Fields read live from state
   assign xram_en = st.system_configuration[`DMBM_XRAM_EN_BIT];
   assign bank_en = st.bank_ctl[`DMBM_BANK_EN_BIT];
   assign bank_sel = st.bank_ctl[3:0];
   assign page = st.page_sel[1:0];
   assign sfr_hit = is_ours(sfr_addr);
   assign sfr_rdata = st.rdata;

   // Register file; no write bypass, the mapping sees a write after the next clock edge
   always_comb begin
      next_st = st;
      if (sfr_wr) begin
         case (sfr_addr)
            `DMBM_PAGE_ADDR: next_st.page_sel = sfr_wdata & reg_mask(sfr_addr);
            `DMBM_BANK_ADDR: next_st.bank_ctl = sfr_wdata & reg_mask(sfr_addr);
            `DMBM_SYSTEM_CONFIGURATION_ADDR: next_st.system_configuration = sfr_wdata & reg_mask(sfr_addr);
            default: next_st = st;
         endcase
      end
      // Unmapped addresses read zero; reserved bits read zero
      if (sfr_rd) begin
         case (sfr_addr)
            `DMBM_PAGE_ADDR: next_st.rdata = st.page_sel;
            `DMBM_BANK_ADDR: next_st.rdata = st.bank_ctl;
            `DMBM_SYSTEM_CONFIGURATION_ADDR: next_st.rdata = st.system_configuration;
            default: next_st.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st.page_sel <= `DMBM_PAGE_RST;
         st.bank_ctl <= `DMBM_BANK_RST;
         st.system_configuration <= `DMBM_SYSTEM_CONFIGURATION_RST;
         st.rdata <= 8'h00;
      end else begin
         st <= next_st;
      end
   end

   // Address mapping, purely combinational so a register write is seen next cycle
   always_comb begin
      map.valid = req.valid;
      map.target = dmbm_pkg::DMBM_T_NONE;
      map.addr = 16'h0000;
      if (req.valid) begin
         case (req.kind)
            dmbm_pkg::DMBM_DIRECT: begin
               if (req.addr8 > `DMBM_DIRECT_TOP) begin
                  map.target = dmbm_pkg::DMBM_T_SFR;
                  map.addr = {8'h00, req.addr8};
               end else if (bank_en && req.addr8 >= `DMBM_WIN_LO) begin
                  // 1KB logical space: top two bank bits pick scratch or expanded
                  if (bank_sel[3:2] == 2'h0) begin
                     map.target = dmbm_pkg::DMBM_T_SCRATCH;
                     map.addr = {8'h00, bank_sel[1:0], req.addr8[5:0]};
                  end else begin
                     // Banks 4-15 cover all 768 expanded bytes, 000h-2FFh
                     map.target = dmbm_pkg::DMBM_T_XRAM;
                     map.addr = {6'h00, bank_sel - 4'h4, req.addr8[5:0]};
                  end
               end else begin
                  // Register banks, bit area, general storage in place
                  map.target = dmbm_pkg::DMBM_T_SCRATCH;
                  map.addr = {8'h00, req.addr8};
               end
            end
            dmbm_pkg::DMBM_INDIRECT: begin
               map.target = dmbm_pkg::DMBM_T_SCRATCH;
               map.addr = {8'h00, req.addr8};
            end
            dmbm_pkg::DMBM_XPTR: begin
               map.addr = req.pointer;
               if (xram_en && req.pointer <= `DMBM_XRAM_TOP) begin
                  map.target = dmbm_pkg::DMBM_T_XRAM;
               end else begin
                  map.target = dmbm_pkg::DMBM_T_EXTERNAL;
               end
            end
            dmbm_pkg::DMBM_XIDX: begin
               if (xram_en && page != `DMBM_PAGE_OFF) begin
                  map.target = dmbm_pkg::DMBM_T_XRAM;
                  map.addr = {6'h00, page, req.addr8};
               end else begin
                  map.target = dmbm_pkg::DMBM_T_EXTERNAL;
                  map.addr = {port_two_latch, req.addr8};
               end
            end
            default: map.target = dmbm_pkg::DMBM_T_NONE;
         endcase
      end
   end

   // Checks beside the logic they guard
   a_reset_values: assert property (@(posedge clk) $rose(resetn) |->
      st.system_configuration == 8'h02 && st.bank_ctl == 8'h01 && st.page_sel == 8'h00)
      else $error("reset values wrong");
   a_ptr_in_range: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_XPTR && xram_en && req.pointer < 16'h0300
      |-> map.target == dmbm_pkg::DMBM_T_XRAM && map.addr == req.pointer)
      else $error("pointer access not on chip");
   a_ptr_beyond: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_XPTR && req.pointer >= 16'h0300
      |-> map.target == dmbm_pkg::DMBM_T_EXTERNAL)
      else $error("pointer beyond range not external");
   a_xram_off: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind[1] && !xram_en |-> map.target == dmbm_pkg::DMBM_T_EXTERNAL)
      else $error("disabled expanded RAM reached");
   a_idx_page: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_XIDX && xram_en && page != 2'h3
      |-> map.target == dmbm_pkg::DMBM_T_XRAM && map.addr == {6'h00, page, req.addr8})
      else $error("index page mapping wrong");
   a_idx_offchip: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_XIDX && page == 2'h3
      |-> map.addr == {port_two_latch, req.addr8})
      else $error("off-chip index address wrong");
   a_bank_window: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_DIRECT && bank_en && req.addr8[7:6] == 2'h1
      && bank_sel >= 4'h4 |-> map.target == dmbm_pkg::DMBM_T_XRAM
      && map.addr[9:0] == {bank_sel, req.addr8[5:0]} - 10'h100)
      else $error("bank window address wrong");
   a_bank_off: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_DIRECT && !bank_en && !req.addr8[7]
      |-> map.target == dmbm_pkg::DMBM_T_SCRATCH && map.addr == {8'h00, req.addr8})
      else $error("direct access disturbed");
   a_write_next: assert property (@(posedge clk) disable iff (!resetn)
      sfr_wr && sfr_addr == 8'h86 |=> st.bank_ctl == ($past(sfr_wdata) & 8'h8f))
      else $error("bank write not taken next cycle");
   a_indirect_hi: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_INDIRECT
      |-> map.target == dmbm_pkg::DMBM_T_SCRATCH && map.addr[7:0] == req.addr8)
      else $error("indirect access misrouted");

   // Decode of our three addresses
   a_hit_decode: assert property (@(posedge clk) disable iff (!resetn)
      sfr_hit == (sfr_addr == 8'h85 || sfr_addr == 8'h86 || sfr_addr == 8'hbf))
      else $error("register decode wrong");

   // Page register read back
   a_rd_page: assert property (@(posedge clk) disable iff (!resetn)
      sfr_rd && sfr_addr == 8'h85 |=> sfr_rdata == $past(st.page_sel))
      else $error("page read wrong");

   // Bank register read back
   a_rd_bank: assert property (@(posedge clk) disable iff (!resetn)
      sfr_rd && sfr_addr == 8'h86 |=> sfr_rdata == $past(st.bank_ctl))
      else $error("bank read wrong");

   // Configuration register read back
   a_rd_conf: assert property (@(posedge clk) disable iff (!resetn)
      sfr_rd && sfr_addr == 8'hbf |=> sfr_rdata == $past(st.system_configuration))
      else $error("configuration read wrong");

   // Foreign addresses read zero
   a_rd_other: assert property (@(posedge clk) disable iff (!resetn)
      sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00)
      else $error("foreign read not zero");

   // Read data stands until the next read
   a_rd_hold: assert property (@(posedge clk) disable iff (!resetn)
      !sfr_rd |=> $stable(sfr_rdata))
      else $error("read data moved");

   // Reserved page bits stay zero
   a_page_resv: assert property (@(posedge clk) disable iff (!resetn)
      st.page_sel[7:2] == 6'h00)
      else $error("page reserved bits set");

   // Reserved bank bits stay zero
   a_bank_resv: assert property (@(posedge clk) disable iff (!resetn)
      st.bank_ctl[6:4] == 3'h0)
      else $error("bank reserved bits set");

   // Reserved configuration bits stay zero
   a_conf_resv: assert property (@(posedge clk) disable iff (!resetn)
      (st.system_configuration & 8'h6c) == 8'h00)
      else $error("configuration reserved bits set");

   // Page write lands on the next clock edge
   a_page_write: assert property (@(posedge clk) disable iff (!resetn)
      sfr_wr && sfr_addr == 8'h85 |=> st.page_sel == ($past(sfr_wdata) & 8'h03))
      else $error("page write not taken");

   // Configuration write lands on the next clock edge
   a_conf_write: assert property (@(posedge clk) disable iff (!resetn)
      sfr_wr && sfr_addr == 8'hbf |=> st.system_configuration == ($past(sfr_wdata) & 8'h93))
      else $error("configuration write not taken");

   // No strobe, no change
   a_regs_hold: assert property (@(posedge clk) disable iff (!resetn)
      !sfr_wr |=> $stable(st.page_sel) && $stable(st.bank_ctl) && $stable(st.system_configuration))
      else $error("register moved without write");

   // Idle core gives no access
   a_map_idle: assert property (@(posedge clk) disable iff (!resetn)
      !req.valid |-> !map.valid && map.target == dmbm_pkg::DMBM_T_NONE)
      else $error("idle access mapped");

   // Valid follows the request
   a_map_valid: assert property (@(posedge clk) disable iff (!resetn)
      map.valid == req.valid)
      else $error("valid not passed through");

   // Every live access lands somewhere
   a_map_some: assert property (@(posedge clk) disable iff (!resetn)
      req.valid |-> map.target != dmbm_pkg::DMBM_T_NONE)
      else $error("live access unmapped");

   // Direct upper half reaches special registers
   a_direct_sfr: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_DIRECT && req.addr8[7]
      |-> map.target == dmbm_pkg::DMBM_T_SFR && map.addr == {8'h00, req.addr8})
      else $error("direct upper access misrouted");

   // Register banks and bit area never banked
   a_direct_low: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_DIRECT && req.addr8 <= 8'h3f
      |-> map.target == dmbm_pkg::DMBM_T_SCRATCH && map.addr == {8'h00, req.addr8})
      else $error("low direct access disturbed");

   // Banks 0-3 stay in scratchpad
   a_win_scratch: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_DIRECT && bank_en && req.addr8[7:6] == 2'h1
      && bank_sel < 4'h4 |-> map.target == dmbm_pkg::DMBM_T_SCRATCH
      && map.addr == {8'h00, bank_sel[1:0], req.addr8[5:0]})
      else $error("scratch bank address wrong");

   // Window off leaves 40h-7Fh in place
   a_win_off: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_DIRECT && !bank_en && req.addr8[7:6] == 2'h1
      |-> map.target == dmbm_pkg::DMBM_T_SCRATCH && map.addr == {8'h00, req.addr8})
      else $error("window active while off");

   // Expanded banks stay inside 768 bytes
   a_win_top: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_DIRECT && bank_en && req.addr8[7:6] == 2'h1
      && bank_sel >= 4'h4 |-> map.addr <= 16'h02ff)
      else $error("bank beyond expanded RAM");

   // Window keeps the low six bits
   a_win_bits: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_DIRECT && bank_en && req.addr8[7:6] == 2'h1
      |-> map.addr[5:0] == req.addr8[5:0])
      else $error("window offset lost");

   // Pointer moves with expanded RAM off
   a_ptr_off: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_XPTR && !xram_en
      |-> map.target == dmbm_pkg::DMBM_T_EXTERNAL && map.addr == req.pointer)
      else $error("pointer move not off chip");

   // Pointer address passes unchanged
   a_ptr_addr: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_XPTR |-> map.addr == req.pointer)
      else $error("pointer address altered");

   // Low pointer addresses on chip when enabled
   a_ptr_low: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_XPTR && xram_en && req.pointer <= 16'h00ff
      |-> map.target == dmbm_pkg::DMBM_T_XRAM)
      else $error("low pointer not on chip");

   // On-chip pointer addresses have no high bits
   a_ptr_hi_zero: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_XPTR && map.target == dmbm_pkg::DMBM_T_XRAM
      |-> map.addr[15:10] == 6'h00)
      else $error("on-chip pointer too high");

   // Index moves with expanded RAM off
   a_idx_off: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_XIDX && !xram_en
      |-> map.target == dmbm_pkg::DMBM_T_EXTERNAL && map.addr == {port_two_latch, req.addr8})
      else $error("index move not off chip");

   // Page three always goes off chip
   a_idx_page3: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_XIDX && page == 2'h3
      |-> map.target == dmbm_pkg::DMBM_T_EXTERNAL)
      else $error("page three kept on chip");

   // Index byte is the low address byte
   a_idx_low: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_XIDX |-> map.addr[7:0] == req.addr8)
      else $error("index byte lost");

   // External moves on chip stay below 300h
   a_xram_range: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind[1] && map.target == dmbm_pkg::DMBM_T_XRAM
      |-> map.addr <= 16'h02ff)
      else $error("expanded address out of range");

   // Lower indirect half in scratchpad
   a_indirect_lo: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_INDIRECT && !req.addr8[7]
      |-> map.target == dmbm_pkg::DMBM_T_SCRATCH && map.addr == {8'h00, req.addr8})
      else $error("lower indirect misrouted");

   // Upper indirect half is plain RAM, never special registers
   a_indirect_up: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_INDIRECT && req.addr8[7]
      |-> map.target == dmbm_pkg::DMBM_T_SCRATCH && map.addr[15:8] == 8'h00)
      else $error("upper indirect misrouted");

   // Direct access outside the live window never reaches expanded RAM
   a_direct_noxr: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && req.kind == dmbm_pkg::DMBM_DIRECT && !(bank_en && req.addr8[7:6] == 2'h1)
      |-> map.target != dmbm_pkg::DMBM_T_XRAM)
      else $error("direct access leaked to expanded RAM");

   // Only external moves leave the chip
   a_ext_kind: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && map.target == dmbm_pkg::DMBM_T_EXTERNAL |-> req.kind[1])
      else $error("internal access sent off chip");

   // Only direct accesses reach special registers
   a_sfr_kind: assert property (@(posedge clk) disable iff (!resetn)
      req.valid && map.target == dmbm_pkg::DMBM_T_SFR
      |-> req.kind == dmbm_pkg::DMBM_DIRECT)
      else $error("special register reached indirectly");

   // Read data clear coming out of reset
   a_rd_reset: assert property (@(posedge clk) $rose(resetn) |-> sfr_rdata == 8'h00)
      else $error("read data not cleared");

   // Bank select field follows the register
   a_bank_field: assert property (@(posedge clk) disable iff (!resetn)
      sfr_wr && sfr_addr == 8'h86 |=> bank_sel == $past(sfr_wdata[3:0]))
      else $error("bank select not taken");

   // Window enable follows the register
   a_bank_enable: assert property (@(posedge clk) disable iff (!resetn)
      sfr_wr && sfr_addr == 8'h86 |=> bank_en == $past(sfr_wdata[7]))
      else $error("window enable not taken");
endmodule
`default_nettype wire

/* File: dv/dmbm_core_model.sv */
// Core-side model issuing data accesses and special register cycles
`timescale 1ns/1ps
`default_nettype none
module dmbm_core_model (
   input wire logic clk, // Core clock
   input wire logic sfr_hit, // Address decode from mapper
   input wire logic [7:0] sfr_rdata, // Registered read data
   output var dmbm_pkg::dmbm_req_s req, // Data access
   output var logic [7:0] port_two_latch, // High byte for off-chip index moves
   output var logic sfr_wr, // Write strobe
   output var logic sfr_rd, // Read strobe
   output var logic [7:0] sfr_addr, // Register address
   output var logic [7:0] sfr_wdata // Write data
);
   // Idle core at time zero
   initial begin
      req = '0;
      port_two_latch = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
   end
   // One access per cycle; pointer high byte doubles as port latch
   task automatic acc(input logic [1:0] k, input logic [7:0] a, input logic [15:0] p);
      @(posedge clk);
      req <= {1'b1, k, a, p};
      port_two_latch <= p[15:8];
      @(negedge clk);
   endtask
   // Strobe for one edge, so the next access already sees the value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask
   // Hit sampled mid-strobe, data the cycle after
   task automatic rd(input logic [7:0] a, output logic h, output logic [7:0] d);
      @(posedge clk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(negedge clk);
      h = sfr_hit;
      @(posedge clk);
      sfr_rd <= 1'b0;
      @(negedge clk);
      d = sfr_rdata;
   endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the data memory bank mapper
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk;
   logic resetn;
   dmbm_pkg::dmbm_req_s req;
   dmbm_pkg::dmbm_map_s map;
   logic [7:0] p2, sa, sw, rdata, pg, bk, sc, d;
   logic swr, srd, hit, h;
   int err_total, comparisons;
   dmbm_mapper uut (.clk(clk), .resetn(resetn), .req(req), .port_two_latch(p2),
      .sfr_wr(swr), .sfr_rd(srd), .sfr_addr(sa), .sfr_wdata(sw), .sfr_rdata(rdata),
      .sfr_hit(hit), .map(map));
   dmbm_core_model core (.clk(clk), .sfr_hit(hit), .sfr_rdata(rdata), .req(req),
      .port_two_latch(p2), .sfr_wr(swr), .sfr_rd(srd), .sfr_addr(sa), .sfr_wdata(sw));
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Expected landing place from the mapping rules and shadow registers
   function automatic logic [19:0] want(input logic [1:0] k, input logic [7:0] a,
      input logic [15:0] p);
      logic [9:0] l;
      l = {bk[3:0], a[5:0]};
      if (k == 2'h1) return {4'h9, 8'h00, a};
      if (k == 2'h3) return (sc[1] && p <= 16'h02ff) ? {4'hb, p} : {4'ha, p};
      if (k == 2'h2) return (sc[1] && pg[1:0] != 2'h3) ? {4'hb, 6'h00, pg[1:0], a} :
         {4'ha, p[15:8], a};
      if (a[7]) return {4'he, 8'h00, a};
      if (!bk[7] || !a[6]) return {4'h9, 8'h00, a};
      return (l[9:8] == 2'h0) ? {4'h9, 8'h00, l[7:0]} : {4'hb, 6'h00, l - 10'h100};
   endfunction
   task automatic go(input logic [1:0] k, input logic [7:0] a, input logic [15:0] p);
      core.acc(k, a, p);
      check(map, want(k, a, p));
   endtask
   // Shadow copies keep only the bits that are stored
   task automatic w(input logic [7:0] a, input logic [7:0] v);
      core.wr(a, v);
      if (a == 8'h85) pg = v & 8'h03;
      if (a == 8'h86) bk = v & 8'h8f;
      if (a == 8'hbf) sc = v & 8'h93;
   endtask
   task automatic r(input logic [7:0] a, input logic [7:0] e);
      core.rd(a, h, d);
      check({19'h0, h}, {19'h0, a == 8'h85 || a == 8'h86 || a == 8'hbf});
      check({12'h0, d}, {12'h0, e});
   endtask
   task automatic t_regs();
      r(8'h85, 8'h00);
      r(8'h86, 8'h01);
      r(8'hbf, 8'h02);
      r(8'h84, 8'h00);
      w(8'h85, 8'hff);
      r(8'h85, 8'h03);
      w(8'h86, 8'hff);
      r(8'h86, 8'h8f);
      w(8'hbf, 8'hff);
      r(8'hbf, 8'h93);
      w(8'h85, 8'h00);
      w(8'hbf, 8'h02);
   endtask
   // Register banks, bit area, general, upper indirect, special regs
   task automatic t_lower();
      w(8'h86, 8'h0f);
      go(2'h0, 8'h1f, 16'h0);
      go(2'h0, 8'h20, 16'h0);
      go(2'h0, 8'h30, 16'h0);
      go(2'h0, 8'h41, 16'h0);
      go(2'h0, 8'h00, 16'h0);
      go(2'h0, 8'h2f, 16'h0);
      go(2'h0, 8'h7f, 16'h0);
      go(2'h1, 8'h30, 16'h0);
      go(2'h1, 8'hff, 16'h0);
      go(2'h0, 8'h90, 16'h0);
   endtask
   // Write then access at once, over every bank that holds RAM
   task automatic t_bank();
      w(8'h86, 8'h88);
      go(2'h0, 8'h41, 16'h0);
      for (int b = 0; b < 16; b++) begin
         w(8'h86, 8'h80 | b[7:0]);
         go(2'h0, 8'h40, 16'h0);
         go(2'h0, 8'h7f, 16'h0);
         go(2'h0, 8'h3f, 16'h0);
      end
      w(8'h86, 8'h01);
      go(2'h0, 8'h41, 16'h0);
   endtask
   task automatic t_ext();
      for (int e = 1; e >= 0; e--) begin
         w(8'hbf, e[0] ? 8'h02 : 8'h00);
         go(2'h3, 8'h00, 16'h0000);
         go(2'h3, 8'h00, 16'h02ff);
         go(2'h3, 8'h00, 16'h0300);
         for (int p = 0; p < 4; p++) begin
            w(8'h85, p[7:0]);
            go(2'h2, 8'ha5, 16'h5a00);
         end
      end
      w(8'hbf, 8'h02);
   endtask
   task automatic test_done();
      $display("err_total %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      err_total = 0;
      comparisons = 0;
      resetn = 1'b0;
      pg = 8'h00;
      bk = 8'h01;
      sc = 8'h02;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_lower();
      t_bank();
      t_ext();
      test_done();
   end
   // Hang guard
   initial begin
      #400000;
      err_total++;
      test_done();
   end
endmodule
`default_nettype wire
